/* src/pwm_timer_pkg.sv */
// constants shared by the pwm timer control block
package pwm_timer_pkg;
	// ********************************************************
	// register indices (byte address is four times the index)
	// ********************************************************
	localparam logic [7:0] IDX_FAULT_MODE = 8'h26; // fault_and_mode_control
	localparam logic [7:0] IDX_OUT_D = 8'h27; // output_d_control
	localparam logic [7:0] IDX_CLK_DT = 8'h2f; // clock_and_deadtime_control
	localparam logic [7:0] IDX_CTRL_A = 8'h30; // out a / out b modes, source
	localparam logic [7:0] IDX_CMP_D = 8'h31; // compare_value_d
	localparam logic [7:0] IDX_TOP = 8'h32; // counter top value
	localparam logic [7:0] IDX_COUNT = 8'h33; // counter_value, read only
	localparam int ADDR_W = 10;

	// ********************************************************
	// reset values
	// ********************************************************
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_TOP = 8'hff;

	// ********************************************************
	// field positions
	// ********************************************************
	localparam int B_INVERT = 7; // pwm_output_invert
	localparam int B_PSC_CLR = 6; // prescaler_clear
	localparam int B_DT_LO = 4; // deadtime_divider_sel [5:4]
	localparam int B_CS_LO = 0; // clock_source_sel [3:0]
	localparam int B_MODE_A_LO = 6; // out_a_mode / shadow [7:6]
	localparam int B_MODE_B_LO = 4; // out_b_mode / shadow [5:4]
	localparam int B_MODE_D_LO = 2; // out_d_mode [3:2]
	localparam int B_FORCE_D = 1; // force_match_d
	localparam int B_PWM_D = 0; // pwm_enable_d
	localparam int B_F_IRQ_EN = 7; // fault_irq_enable
	localparam int B_F_MODE_EN = 6; // fault_mode_enable
	localparam int B_F_FILTER = 5; // fault_noise_filter
	localparam int B_F_EDGE = 4; // fault_edge_sel
	localparam int B_F_CMP_SRC = 3; // fault source is analog comparator
	localparam int B_F_FLAG = 2; // fault_flag
	localparam int B_WGM_LO = 0; // waveform_mode_sel [1:0]
	localparam int B_FAST_SRC = 0; // ctrl a: count fast_peripheral_clk

	// ********************************************************
	// encodings and timing
	// ********************************************************
	localparam logic [1:0] MODE_OFF = 2'b00;
	localparam logic [1:0] MODE_TOGGLE = 2'b01;
	localparam logic [1:0] MODE_CLEAR = 2'b10;
	localparam logic [1:0] MODE_SET = 2'b11;
	localparam logic [3:0] CS_STOP = 4'h0;
	localparam int FILTER_SAMPLES = 4;
	localparam logic [3:0] DEADTIME_TICKS = 4'h3; // dead-time ticks
endpackage

/* src/fault_front.sv */
// fault input noise filter and edge detector
`timescale 1ns/100ps
module fault_front
(
	input wire logic i_clk_sys, // system clock
	input wire logic i_nrst, // async reset, active low
	input wire logic i_raw, // selected fault source
	input wire logic i_filter_en, // noise filter on
	input wire logic i_rising_sel, // 1 rising edge, 0 falling edge
	output logic o_event // one-cycle fault event pulse
);
	logic [pwm_timer_pkg::FILTER_SAMPLES-1:0] hist_ff;
	logic filt_ff;
	logic prev_ff;
	logic level;

	// sample history; the filtered level moves only on equal samples
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			hist_ff <= '0;
			filt_ff <= 1'b0;
		end
		else
		begin
			hist_ff <= {hist_ff[pwm_timer_pkg::FILTER_SAMPLES-2:0], i_raw};
			if (&hist_ff)
				filt_ff <= 1'b1;
			else if (~|hist_ff)
				filt_ff <= 1'b0;
		end
	end

	// filter bypassed means the raw level is used directly
	assign level = i_filter_en ? filt_ff : i_raw;

	// edge detection on the chosen polarity
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			prev_ff <= 1'b0;
			o_event <= 1'b0;
		end
		else
		begin
			prev_ff <= level;
			o_event <= i_rising_sel ? (level & ~prev_ff)
				: (~level & prev_ff);
		end
	end
endmodule

/* src/pwm_timer_ctrl.sv */
// pwm timer control registers, prescalers and compare channel d
//
// Local design decision: the APB register port.
`timescale 1ns/100ps
module pwm_timer_ctrl
(
	input wire logic i_clk_sys, // system clock, 100 mhz
	input wire logic i_nrst, // async reset, active low
	input wire logic [9:0] i_paddr, // apb byte address
	input wire logic i_psel, // apb select
	input wire logic i_penable, // apb enable
	input wire logic i_pwrite, // apb write
	input wire logic [31:0] i_pwdata, // apb write data
	output logic [31:0] o_prdata, // apb read data
	output logic o_pready, // apb ready
	output logic o_pslverr, // apb error, unmapped address
	input wire logic i_fast_peripheral_tick, // fast clock edge, pulse
	input wire logic i_fault_input_pin, // fault pin level
	input wire logic i_analog_cmp, // analog comparator level
	input wire logic i_fault_vector_ack, // fault vector executed
	output logic o_fault_irq, // fault interrupt request
	output logic o_compare_pin_d, // true channel d output
	output logic o_compare_pin_d_n, // complementary channel d output
	output logic o_pin_d_override, // true pin taken from port
	output logic o_pin_d_n_override, // complementary pin taken
	output logic [1:0] o_out_a_mode, // channel a output mode
	output logic [1:0] o_out_b_mode, // channel b output mode
	output logic [1:0] o_waveform_mode_sel, // waveform mode bits
	output logic o_fault_mode_enable // fault protection active
);
	// ********************************************************
	// state
	// ********************************************************
	logic inv_ff;
	logic [1:0] dtsel_ff;
	logic [3:0] cs_ff;
	logic [1:0] mode_a_ff;
	logic [1:0] mode_b_ff;
	logic [1:0] mode_d_ff;
	logic pwm_d_ff;
	logic f_irq_en_ff;
	logic f_mode_en_ff;
	logic f_filter_ff;
	logic f_edge_ff;
	logic f_cmp_src_ff;
	logic f_flag_ff;
	logic f_clr_ff;
	logic [1:0] wgm_ff;
	logic fast_src_ff;
	logic [7:0] cmp_d_ff;
	logic [7:0] top_ff;
	logic [7:0] cnt_ff;
	logic down_ff;
	logic [13:0] presc_ff;
	logic [2:0] dt_presc_ff;
	logic [3:0] dt_cnt_ff;
	logic wave_ff;
	logic wave_prev_ff;

	logic setup;
	logic acc;
	logic wr;
	logic [7:0] idx;
	logic mapped;
	logic [7:0] rd8;
	logic src_tick;
	logic [13:0] pmask;
	logic tick;
	logic [2:0] dtmask;
	logic dt_tick;
	logic dual;
	logic match;
	logic force_d;
	logic fault_ev;
	logic nxt_wave;
	logic dt_true;
	logic dt_comp;

	// ********************************************************
	// apb slave
	// ********************************************************
	assign setup = i_psel & ~i_penable;
	assign acc = i_psel & i_penable & o_pready;
	assign wr = acc & i_pwrite;
	assign idx = i_paddr[9:2];

	// decode; misaligned byte addresses are treated as unmapped
	always_comb
	begin
		mapped = 1'b0;
		case (idx)
			pwm_timer_pkg::IDX_FAULT_MODE,
			pwm_timer_pkg::IDX_OUT_D,
			pwm_timer_pkg::IDX_CLK_DT,
			pwm_timer_pkg::IDX_CTRL_A,
			pwm_timer_pkg::IDX_CMP_D,
			pwm_timer_pkg::IDX_TOP,
			pwm_timer_pkg::IDX_COUNT:
				mapped = (i_paddr[1:0] == 2'b00);
			default:
				mapped = 1'b0;
		endcase
	end

	// read mux; prescaler clear and force bits always read as zero
	always_comb
	begin
		case (idx)
			pwm_timer_pkg::IDX_FAULT_MODE:
				rd8 = {f_irq_en_ff, f_mode_en_ff, f_filter_ff, f_edge_ff,
					f_cmp_src_ff, f_flag_ff, wgm_ff};
			pwm_timer_pkg::IDX_OUT_D:
				rd8 = {mode_a_ff, mode_b_ff, mode_d_ff, 1'b0, pwm_d_ff};
			pwm_timer_pkg::IDX_CLK_DT:
				rd8 = {inv_ff, 1'b0, dtsel_ff, cs_ff};
			pwm_timer_pkg::IDX_CTRL_A:
				rd8 = {mode_a_ff, mode_b_ff, 3'h0, fast_src_ff};
			pwm_timer_pkg::IDX_CMP_D:
				rd8 = cmp_d_ff;
			pwm_timer_pkg::IDX_TOP:
				rd8 = top_ff;
			pwm_timer_pkg::IDX_COUNT:
				rd8 = cnt_ff;
			default:
				rd8 = 8'h00;
		endcase
	end

	// answer one cycle after setup; data captured during setup
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h0000_0000;
		end
		else
		begin
			o_pready <= setup;
			o_pslverr <= setup & ~mapped;
			if (setup)
				o_prdata <= (mapped & ~i_pwrite) ? {24'h00_0000, rd8}
					: 32'h0000_0000;
		end
	end

	// ********************************************************
	// control registers
	// ********************************************************
	// out a/b modes live once so both addresses always agree
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			mode_a_ff <= 2'b00;
			mode_b_ff <= 2'b00;
			fast_src_ff <= 1'b0;
		end
		else if (wr && mapped && (idx == pwm_timer_pkg::IDX_OUT_D
			|| idx == pwm_timer_pkg::IDX_CTRL_A))
		begin
			mode_a_ff <= i_pwdata[pwm_timer_pkg::B_MODE_A_LO+:2];
			mode_b_ff <= i_pwdata[pwm_timer_pkg::B_MODE_B_LO+:2];
			if (idx == pwm_timer_pkg::IDX_CTRL_A)
				fast_src_ff <= i_pwdata[pwm_timer_pkg::B_FAST_SRC];
		end
	end

	// channel d; a fault in fault mode disconnects the pins
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			mode_d_ff <= pwm_timer_pkg::MODE_OFF;
			pwm_d_ff <= 1'b0;
		end
		else if (f_mode_en_ff && fault_ev)
			mode_d_ff <= pwm_timer_pkg::MODE_OFF;
		else if (wr && mapped && idx == pwm_timer_pkg::IDX_OUT_D)
		begin
			mode_d_ff <= i_pwdata[pwm_timer_pkg::B_MODE_D_LO+:2];
			pwm_d_ff <= i_pwdata[pwm_timer_pkg::B_PWM_D];
		end
	end

	// clock, dead-time and inversion controls
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			inv_ff <= 1'b0;
			dtsel_ff <= 2'b00;
			cs_ff <= pwm_timer_pkg::CS_STOP;
		end
		else if (wr && mapped && idx == pwm_timer_pkg::IDX_CLK_DT)
		begin
			inv_ff <= i_pwdata[pwm_timer_pkg::B_INVERT];
			dtsel_ff <= i_pwdata[pwm_timer_pkg::B_DT_LO+:2];
			cs_ff <= i_pwdata[pwm_timer_pkg::B_CS_LO+:4];
		end
	end

	// fault configuration and compare/top values
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			{f_irq_en_ff, f_mode_en_ff, f_filter_ff} <= 3'h0;
			{f_edge_ff, f_cmp_src_ff} <= 2'h0;
			wgm_ff <= 2'b00;
			cmp_d_ff <= pwm_timer_pkg::RST_CTRL;
			top_ff <= pwm_timer_pkg::RST_TOP;
		end
		else if (wr && mapped)
		begin
			if (idx == pwm_timer_pkg::IDX_FAULT_MODE)
			begin
				f_irq_en_ff <= i_pwdata[pwm_timer_pkg::B_F_IRQ_EN];
				f_mode_en_ff <= i_pwdata[pwm_timer_pkg::B_F_MODE_EN];
				f_filter_ff <= i_pwdata[pwm_timer_pkg::B_F_FILTER];
				f_edge_ff <= i_pwdata[pwm_timer_pkg::B_F_EDGE];
				f_cmp_src_ff <= i_pwdata[pwm_timer_pkg::B_F_CMP_SRC];
				wgm_ff <= i_pwdata[pwm_timer_pkg::B_WGM_LO+:2];
			end
			if (idx == pwm_timer_pkg::IDX_CMP_D)
				cmp_d_ff <= i_pwdata[7:0];
			if (idx == pwm_timer_pkg::IDX_TOP)
				top_ff <= i_pwdata[7:0];
		end
	end

	// ********************************************************
	// fault front end and flag
	// ********************************************************
	fault_front u_fault_front
	(
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_raw(f_cmp_src_ff ? i_analog_cmp : i_fault_input_pin),
		.i_filter_en(f_filter_ff),
		.i_rising_sel(f_edge_ff),
		.o_event(fault_ev)
	);

	// write-one clear lands a cycle later; a new event beats the clear
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			f_clr_ff <= 1'b0;
			f_flag_ff <= 1'b0;
			o_fault_irq <= 1'b0;
		end
		else
		begin
			f_clr_ff <= wr && mapped && idx == pwm_timer_pkg::IDX_FAULT_MODE
				&& i_pwdata[pwm_timer_pkg::B_F_FLAG];
			if (fault_ev)
				f_flag_ff <= 1'b1;
			else if (f_clr_ff || i_fault_vector_ack)
				f_flag_ff <= 1'b0;
			o_fault_irq <= f_flag_ff & f_irq_en_ff;
		end
	end

	// ********************************************************
	// counter prescaler and counter
	// ********************************************************
	assign src_tick = fast_src_ff ? i_fast_peripheral_tick : 1'b1;
	assign pmask = (cs_ff == pwm_timer_pkg::CS_STOP) ? 14'h0000
		: ((14'h0001 << (cs_ff - 4'h1)) - 14'h0001);
	assign tick = (cs_ff != pwm_timer_pkg::CS_STOP) & src_tick
		& ((presc_ff & pmask) == pmask);

	// prescaler clear is acted on at the write edge, never stored
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
			presc_ff <= 14'h0000;
		else if (wr && mapped && idx == pwm_timer_pkg::IDX_CLK_DT
			&& i_pwdata[pwm_timer_pkg::B_PSC_CLR])
			presc_ff <= 14'h0000;
		else if (tick && pmask == 14'h0000)
			presc_ff <= 14'h0000;
		else if (tick)
			presc_ff <= 14'h0000;
		else if (src_tick && cs_ff != pwm_timer_pkg::CS_STOP)
			presc_ff <= presc_ff + 14'h0001;
	end

	// dual slope for waveform modes 01 and 11 while pwm is on
	assign dual = pwm_d_ff & wgm_ff[0];

	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			cnt_ff <= 8'h00;
			down_ff <= 1'b0;
		end
		else if (tick)
		begin
			if (!dual)
				cnt_ff <= (cnt_ff == top_ff) ? 8'h00 : cnt_ff + 8'h01;
			else if (down_ff)
			begin
				down_ff <= (cnt_ff != 8'h00);
				cnt_ff <= (cnt_ff == 8'h00) ? 8'h01 : cnt_ff - 8'h01;
			end
			else
			begin
				down_ff <= (cnt_ff == top_ff);
				cnt_ff <= (cnt_ff == top_ff) ? cnt_ff - 8'h01
					: cnt_ff + 8'h01;
			end
		end
	end

	// ********************************************************
	// waveform output d
	// ********************************************************
	function automatic logic mode_action(input logic [1:0] m,
		input logic w);
		case (m)
			pwm_timer_pkg::MODE_TOGGLE: mode_action = ~w;
			pwm_timer_pkg::MODE_CLEAR: mode_action = 1'b0;
			pwm_timer_pkg::MODE_SET: mode_action = 1'b1;
			default: mode_action = w;
		endcase
	endfunction

	assign match = tick & (cnt_ff == cmp_d_ff);
	// force uses the mode and pwm bits written in the same access
	assign force_d = wr & mapped & (idx == pwm_timer_pkg::IDX_OUT_D)
		& i_pwdata[pwm_timer_pkg::B_FORCE_D]
		& ~i_pwdata[pwm_timer_pkg::B_PWM_D];

	always_comb
	begin
		nxt_wave = wave_ff;
		if (force_d)
			nxt_wave = mode_action(
				i_pwdata[pwm_timer_pkg::B_MODE_D_LO+:2], wave_ff);
		else if (!pwm_d_ff)
		begin
			if (match)
				nxt_wave = mode_action(mode_d_ff, wave_ff);
		end
		else if (mode_d_ff != pwm_timer_pkg::MODE_OFF)
		begin
			if (dual && match)
				nxt_wave = (mode_d_ff == pwm_timer_pkg::MODE_SET)
					^ down_ff;
			else if (!dual && match)
				nxt_wave = (mode_d_ff == pwm_timer_pkg::MODE_SET);
			else if (!dual && tick && cnt_ff == 8'h00)
				nxt_wave = (mode_d_ff != pwm_timer_pkg::MODE_SET);
		end
	end

	// ********************************************************
	// dead-time prescaler and generator
	// ********************************************************
	assign dtmask = (3'h1 << dtsel_ff) - 3'h1;
	assign dt_tick = tick & ((dt_presc_ff & dtmask) == dtmask);

	// every waveform edge restarts the dead-time window
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			wave_ff <= 1'b0;
			wave_prev_ff <= 1'b0;
			dt_presc_ff <= 3'h0;
			dt_cnt_ff <= 4'h0;
		end
		else
		begin
			wave_ff <= nxt_wave;
			wave_prev_ff <= wave_ff;
			if (tick)
				dt_presc_ff <= dt_tick ? 3'h0 : dt_presc_ff + 3'h1;
			if (wave_ff != wave_prev_ff)
				dt_cnt_ff <= pwm_timer_pkg::DEADTIME_TICKS;
			else if (dt_tick && dt_cnt_ff != 4'h0)
				dt_cnt_ff <= dt_cnt_ff - 4'h1;
		end
	end

	assign dt_true = wave_ff & (dt_cnt_ff == 4'h0);
	assign dt_comp = ~wave_ff & (dt_cnt_ff == 4'h0);

	// ********************************************************
	// pin drivers
	// ********************************************************
	// pin direction is the port's job; these only pick the source
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_compare_pin_d <= 1'b0;
			o_compare_pin_d_n <= 1'b0;
			o_pin_d_override <= 1'b0;
			o_pin_d_n_override <= 1'b0;
		end
		else
		begin
			o_compare_pin_d <= pwm_d_ff ? (dt_true ^ inv_ff)
				: wave_ff;
			o_compare_pin_d_n <= pwm_d_ff & (dt_comp ^ inv_ff);
			o_pin_d_override <= (mode_d_ff != pwm_timer_pkg::MODE_OFF);
			o_pin_d_n_override <= pwm_d_ff
				& (mode_d_ff == pwm_timer_pkg::MODE_TOGGLE);
		end
	end

	// mirrored controls for neighbouring logic
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_out_a_mode <= 2'b00;
			o_out_b_mode <= 2'b00;
			o_waveform_mode_sel <= 2'b00;
			o_fault_mode_enable <= 1'b0;
		end
		else
		begin
			o_out_a_mode <= mode_a_ff;
			o_out_b_mode <= mode_b_ff;
			o_waveform_mode_sel <= wgm_ff;
			o_fault_mode_enable <= f_mode_en_ff;
		end
	end

	// ********************************************************
	// checks
	// ********************************************************
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);

	property p_stop_holds;
		(cs_ff == pwm_timer_pkg::CS_STOP) [*2] |-> $stable(cnt_ff);
	endproperty
	a_stop_holds: assert property (p_stop_holds)
		else $error("counter moved while stopped");

	property p_psc_clear;
		wr && mapped && idx == pwm_timer_pkg::IDX_CLK_DT
			&& i_pwdata[pwm_timer_pkg::B_PSC_CLR] |=> presc_ff == 14'h0000;
	endproperty
	a_psc_clear: assert property (p_psc_clear)
		else $error("prescaler not cleared");

	property p_psc_reads_zero;
		o_pready |-> !o_prdata[pwm_timer_pkg::B_PSC_CLR]
			|| $past(idx) != pwm_timer_pkg::IDX_CLK_DT;
	endproperty
	a_psc_reads_zero: assert property (p_psc_reads_zero)
		else $error("prescaler clear read back as one");

	property p_shadow_a;
		wr && mapped && idx == pwm_timer_pkg::IDX_CTRL_A
			|=> ##1 o_out_a_mode == $past(i_pwdata[7:6], 2);
	endproperty
	a_shadow_a: assert property (p_shadow_a)
		else $error("out a mode not mirrored");

	property p_shadow_b;
		wr && mapped && idx == pwm_timer_pkg::IDX_OUT_D
			|=> mode_b_ff == $past(i_pwdata[5:4]);
	endproperty
	a_shadow_b: assert property (p_shadow_b)
		else $error("out b shadow not mirrored");

	property p_override_off;
		wr && mapped && idx == pwm_timer_pkg::IDX_OUT_D
			&& i_pwdata[3:2] == 2'b00 |=> ##1 !o_pin_d_override;
	endproperty
	a_override_off: assert property (p_override_off)
		else $error("pin override with mode off");

	property p_comp_pin;
		o_pin_d_n_override |-> $past(pwm_d_ff)
			&& $past(mode_d_ff) == pwm_timer_pkg::MODE_TOGGLE;
	endproperty
	a_comp_pin: assert property (p_comp_pin)
		else $error("complement pin connected outside pwm 01");

	property p_force_toggle;
		force_d && i_pwdata[3:2] == pwm_timer_pkg::MODE_TOGGLE
			|=> wave_ff != $past(wave_ff);
	endproperty
	a_force_toggle: assert property (p_force_toggle)
		else $error("force did not toggle waveform");

	property p_flag_clear;
		wr && mapped && idx == pwm_timer_pkg::IDX_FAULT_MODE
			&& i_pwdata[pwm_timer_pkg::B_F_FLAG] ##1 !fault_ev
			|=> !f_flag_ff;
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("fault flag not cleared");

	property p_irq_cause;
		o_fault_irq |-> $past(f_flag_ff) && $past(f_irq_en_ff);
	endproperty
	a_irq_cause: assert property (p_irq_cause)
		else $error("fault irq without enabled flag");
endmodule

/* tb/power_stage_model.sv */
// external power stage model loaded by the channel d pins
`timescale 1ns/100ps
module power_stage_model
(
	input wire logic i_dir, // port direction bit for pin d
	input wire logic i_pin_d, // true compare output
	input wire logic i_pin_d_n, // complementary compare output
	input wire logic i_ovr, // true pin taken from port
	input wire logic i_ovr_n, // complementary pin taken
	output logic o_high_side, // high side gate level
	output logic o_low_side // low side gate level
);
	// an undriven gate sits at its pull-down, never at the last value
	assign o_high_side = (i_dir & i_ovr) ? i_pin_d : 1'b0;
	assign o_low_side = (i_dir & i_ovr_n) ? i_pin_d_n : 1'b0;
endmodule

/* tb/pwm_timer_ctrl_tb.sv */
// self-checking bench for the pwm timer control block
`timescale 1ns/100ps
module pwm_timer_ctrl_tb;
	logic clk, nrst, psel, pen, pwr, pin, ack, dir, rdy, err;
	logic pd, pdn, ov, ovn, hs, ls, irq, fme;
	logic [1:0] ma, mb, wm;
	logic [9:0] addr;
	logic [31:0] wdata, rdata, rv, c0;
	int n_errors = 0;
	int compares = 0;
	logic [1:0] fm [5] = '{2'b11, 2'b10, 2'b01, 2'b01, 2'b00};
	logic fp [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

	pwm_timer_ctrl dut_u
	(
		.i_clk_sys(clk), .i_nrst(nrst), .i_paddr(addr), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_pwdata(wdata),
		.o_prdata(rdata), .o_pready(rdy), .o_pslverr(err),
		.i_fast_peripheral_tick(1'b0), .i_fault_input_pin(pin),
		.i_analog_cmp(1'b0), .i_fault_vector_ack(ack), .o_fault_irq(irq),
		.o_compare_pin_d(pd), .o_compare_pin_d_n(pdn),
		.o_pin_d_override(ov), .o_pin_d_n_override(ovn),
		.o_out_a_mode(ma), .o_out_b_mode(mb),
		.o_waveform_mode_sel(wm), .o_fault_mode_enable(fme)
	);

	power_stage_model load_u
	(
		.i_dir(dir), .i_pin_d(pd), .i_pin_d_n(pdn), .i_ovr(ov),
		.i_ovr_n(ovn), .o_high_side(hs), .o_low_side(ls)
	);

	// free running 100 mhz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ****************************************
	// bus and compare helpers
	// ****************************************
	// request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [9:0] a,
		input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		addr <= a;
		wdata <= {24'h000000, d};
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (rdy !== 1'b1)
			@(posedge clk);
		rv = rdata;
		c0[0] = err;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask

	task automatic rd(input logic [9:0] a, input logic [7:0] e,
		input string nm);
		apb(1'b0, a, 8'h00);
		chk(nm, {24'h000000, e}, rv);
	endtask

	task automatic complete_run;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	// stopped counter, then divide by 1 and by 4; back to back reads
	// capture three cycles apart, so 3 counts at 1 and 1 count at 4
	task automatic t_count;
		logic [7:0] b;
		repeat (20) @(posedge clk);
		rd(10'h0cc, 8'h00, "stopped count");
		apb(1'b1, 10'h0bc, 8'h41);
		rd(10'h0bc, 8'h01, "clear reads zero");
		apb(1'b0, 10'h0cc, 8'h00);
		b = rv[7:0] + 8'h03;
		rd(10'h0cc, b, "count div 1");
		apb(1'b1, 10'h0bc, 8'h43);
		apb(1'b0, 10'h0cc, 8'h00);
		b = rv[7:0] + 8'h01;
		rd(10'h0cc, b, "count div 4");
		apb(1'b1, 10'h0bc, 8'h00);
	endtask

	// mode bits written through either location show in both
	task automatic t_shadow;
		apb(1'b1, 10'h0c0, 8'h90);
		rd(10'h09c, 8'h90, "shadow ab");
		apb(1'b1, 10'h09c, 8'h60);
		rd(10'h0c0, 8'h60, "ctrl a ab");
		chk("a mode", 32'h1, {30'h0, ma});
		chk("b mode", 32'h2, {30'h0, mb});
	endtask

	// forced set, clear, toggle twice, then normal port
	task automatic t_force;
		dir <= 1'b1;
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b1, 10'h09c, {4'h0, fm[i], 2'b10});
			repeat (4) @(posedge clk);
			chk("pin d", {31'h0, fp[i]}, {31'h0, pd});
			chk("override", {31'h0, fm[i] != 2'b00}, {31'h0, ov});
			chk("load", {31'h0, fp[i] & ov}, {31'h0, hs});
			chk("n override", 32'h0, {31'h0, ovn});
			rd(10'h09c, {4'h0, fm[i], 2'b00}, "force reads 0");
		end
	endtask

	// complementary pin only in pwm with mode 01
	task automatic t_pwm;
		apb(1'b1, 10'h09c, 8'h05);
		repeat (4) @(posedge clk);
		chk("pwm n override", 32'h1, {31'h0, ovn});
		// stopped timer holds the dead time, inversion lifts both pins
		apb(1'b1, 10'h0bc, 8'h80);
		repeat (4) @(posedge clk);
		chk("inv pin d", 32'h1, {31'h0, pd});
		chk("inv pin d n", 32'h1, {31'h0, pdn});
		chk("low side", 32'h1, {31'h0, ls});
		apb(1'b1, 10'h0bc, 8'h00);
		apb(1'b1, 10'h09c, 8'h09);
		repeat (4) @(posedge clk);
		chk("mode 10 n override", 32'h0, {31'h0, ovn});
	endtask

	// falling edge raises the flag; ack and write one clear it
	task automatic t_fault;
		apb(1'b1, 10'h098, 8'hc3);
		repeat (2) @(posedge clk);
		chk("fault mode", 32'h1, {31'h0, fme});
		chk("waveform", 32'h3, {30'h0, wm});
		apb(1'b1, 10'h098, 8'h80);
		pin <= 1'b0;
		repeat (10) @(posedge clk);
		chk("irq", 32'h1, {31'h0, irq});
		rd(10'h098, 8'h84, "flag");
		pin <= 1'b1;
		ack <= 1'b1;
		@(posedge clk);
		ack <= 1'b0;
		repeat (10) @(posedge clk);
		chk("irq ack", 32'h0, {31'h0, irq});
		pin <= 1'b0;
		repeat (10) @(posedge clk);
		chk("irq again", 32'h1, {31'h0, irq});
		apb(1'b1, 10'h098, 8'h84);
		repeat (4) @(posedge clk);
		chk("irq w1c", 32'h0, {31'h0, irq});
	endtask

	// hang guard, far beyond the few hundred cycles the run needs
	initial
	begin
		repeat (20000) @(posedge clk);
		n_errors++;
		complete_run();
	end

	// main sequence
	initial
	begin
		nrst <= 1'b0;
		psel <= 1'b0;
		pen <= 1'b0;
		pwr <= 1'b0;
		addr <= 10'h000;
		wdata <= 32'h00000000;
		pin <= 1'b1;
		ack <= 1'b0;
		dir <= 1'b0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		rd(10'h098, 8'h00, "fault reset");
		rd(10'h09c, 8'h00, "out d reset");
		rd(10'h0bc, 8'h00, "clock reset");
		rd(10'h0c8, 8'hff, "top reset");
		apb(1'b0, 10'h000, 8'h00);
		chk("unmapped", 32'h1, {31'h0, c0[0]});
		t_count();
		t_shadow();
		t_force();
		t_pwm();
		t_fault();
		complete_run();
	end
endmodule
